// file: core/multichannel_decimator.sv
// Multichannel decimator top: clock divider, shared decimation phase, settling, output strobe.
// Assumes modulator bits are produced on this clock; mode and divide select are pins.
`include "decim_defines.svh"
`default_nettype none
module multichannel_decimator #(
	parameter int CHANNELS  = 8,
	parameter int ACC_WIDTH = 30
) (
	input  wire logic                                   clock,
	input  wire logic                                   rst_n,
	input  wire logic [1:0]                             modePins,
	input  wire logic                                   clock_divide_select,
	input  wire logic [CHANNELS-1:0]                    modBits,
	output logic                                        modTick,
	output logic                                        dataStrobe,
	output logic                                        settled,
	output logic      [CHANNELS*`RESULT_WIDTH-1:0]      results
);
	// Pins come from outside this domain: two flops before any decode
	logic [1:0] modeMeta_r, modeSync_r;
	logic       divMeta_r, divSync_r;
	decim_pkg::op_mode_type   mode;
	decim_pkg::mode_cfg_type  cfg;
	decim_pkg::op_mode_type   modePrev_r, modePrev_nxt;
	logic [5:0] divCnt_r, divCnt_nxt;
	logic [7:0] phase_r, phase_nxt;
	logic [6:0] settleCnt_r, settleCnt_nxt;
	decim_pkg::settle_state_type state_r, state_nxt;
	logic       modTick_r, modTick_nxt;
	logic       strobe_r, strobe_nxt;
	logic       outTick, restart;

	function automatic decim_pkg::mode_cfg_type decode(input decim_pkg::op_mode_type m, input logic div);
		decode.settleCount = `SETTLE_NORMAL;
		decode.ratio       = `OSR_NORMAL;
		case (m)
			decim_pkg::MODE_HIGH_SPEED: decode.clockDivide = `DIV_FAST;
			decim_pkg::MODE_HIGH_RES: begin
				decode.clockDivide = `DIV_FAST;
				decode.ratio       = `OSR_HIGHRES;
				decode.settleCount = `SETTLE_HIGHRES;
			end
			decim_pkg::MODE_LOW_POWER: decode.clockDivide = div ? `DIV_MID : `DIV_FAST;
			decim_pkg::MODE_LOW_SPEED: decode.clockDivide = div ? `DIV_SLOW : `DIV_MID;
			default: decode.clockDivide = `DIV_FAST;
		endcase
	endfunction

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			modeMeta_r <= 2'h0;
			modeSync_r <= 2'h0;
			divMeta_r  <= 1'b0;
			divSync_r  <= 1'b0;
		end else begin
			modeMeta_r <= modePins;
			modeSync_r <= modeMeta_r;
			divMeta_r  <= clock_divide_select;
			divSync_r  <= divMeta_r;
		end
	end

	assign mode = decim_pkg::op_mode_type'(modeSync_r);
	assign cfg  = decode(mode, divSync_r);
	// A mode change restarts every channel together, keeping them aligned; a divide select change does not restart
	assign restart = (mode != modePrev_r);
	assign outTick = (phase_r == cfg.ratio - 8'h01);

	always_comb begin
		modePrev_nxt  = mode;
		divCnt_nxt    = divCnt_r;
		phase_nxt     = phase_r;
		modTick_nxt   = 1'b0;
		strobe_nxt    = 1'b0;
		settleCnt_nxt = settleCnt_r;
		state_nxt     = state_r;
		if (restart) begin
			divCnt_nxt    = 6'h00;
			phase_nxt     = 8'h00;
			settleCnt_nxt = 7'h00;
			state_nxt     = decim_pkg::ST_SETTLING;
		end else begin
			if (divCnt_r >= cfg.clockDivide - 6'h01) begin
				divCnt_nxt  = 6'h00;
				modTick_nxt = 1'b1;
			end else
				divCnt_nxt = divCnt_r + 6'h01;
			if (modTick_r) begin
				phase_nxt = outTick ? 8'h00 : phase_r + 8'h01;
				if (outTick) begin
					strobe_nxt = 1'b1;
					case (state_r)
						decim_pkg::ST_SETTLING: begin
							settleCnt_nxt = settleCnt_r + 7'h01;
							if (settleCnt_r + 7'h01 >= cfg.settleCount)
								state_nxt = decim_pkg::ST_RUNNING;
						end
						decim_pkg::ST_RUNNING: state_nxt = decim_pkg::ST_RUNNING;
						default: state_nxt = decim_pkg::ST_SETTLING;
					endcase
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			modePrev_r  <= decim_pkg::MODE_HIGH_SPEED;
			divCnt_r    <= 6'h00;
			phase_r     <= 8'h00;
			settleCnt_r <= 7'h00;
			state_r     <= decim_pkg::ST_SETTLING;
			modTick_r   <= 1'b0;
			strobe_r    <= 1'b0;
		end else begin
			modePrev_r  <= modePrev_nxt;
			divCnt_r    <= divCnt_nxt;
			phase_r     <= phase_nxt;
			settleCnt_r <= settleCnt_nxt;
			state_r     <= state_nxt;
			modTick_r   <= modTick_nxt;
			strobe_r    <= strobe_nxt;
		end
	end

	// Sinc filter is a simplification: linear phase holds, stop band falls short of a real FIR
	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
		decim_channel #(.ACC_WIDTH(ACC_WIDTH)) u_ch (
			.clock   (clock),
			.rst_n   (rst_n),
			.modTick (modTick_r),
			.outTick (outTick),
			.restart (restart),
			.modBit  (modBits[ch]),
			.ratio   (cfg.ratio),
			.result  (results[ch*`RESULT_WIDTH +: `RESULT_WIDTH])
		);
	end

	assign modTick    = modTick_r;
	assign dataStrobe = strobe_r;
	assign settled    = (state_r == decim_pkg::ST_RUNNING);

	sequence s_tick_gap4;
		modTick_r ##1 !modTick_r [*3] ##1 modTick_r;
	endsequence
	a_tick_fast: assert property (@(posedge clock) disable iff (!rst_n)
		(modTick_r && cfg.clockDivide == `DIV_FAST && $stable(cfg) && !restart) |-> ##1 !modTick_r [*3])
		else $error("fast divider tick spacing wrong");
	a_tick_mid: assert property (@(posedge clock) disable iff (!rst_n)
		(modTick_r && cfg.clockDivide == `DIV_MID && !restart) |-> ##1 (!modTick_r || restart) [*7])
		else $error("mid divider tick spacing wrong");
	a_phase_wrap: assert property (@(posedge clock) disable iff (!rst_n)
		(modTick_r && outTick && !restart) |=> phase_r == 8'h00 && dataStrobe)
		else $error("phase did not wrap at ratio");
	a_phase_bound: assert property (@(posedge clock) disable iff (!rst_n)
		phase_r < cfg.ratio || $changed(cfg))
		else $error("phase beyond ratio");
	a_strobe_cause: assert property (@(posedge clock) disable iff (!rst_n)
		dataStrobe |-> $past(modTick_r) && $past(outTick))
		else $error("strobe without conversion");
	a_settle_gate: assert property (@(posedge clock) disable iff (!rst_n)
		settled |-> settleCnt_r >= cfg.settleCount || $changed(cfg))
		else $error("settled too early");
	a_restart_align: assert property (@(posedge clock) disable iff (!rst_n)
		restart |=> phase_r == 8'h00 && !settled)
		else $error("restart did not realign");
	a_mode_decode: assert property (@(posedge clock) disable iff (!rst_n)
		(mode == decim_pkg::MODE_HIGH_RES) |-> cfg.ratio == `OSR_HIGHRES && cfg.settleCount == `SETTLE_HIGHRES)
		else $error("high-res decode wrong");
endmodule
`default_nettype wire

// file: shared/decim_defines.svh
// Constants of the multichannel decimator: dividers, ratios, settling counts, code limits.
// Assumes inclusion by bare name from the package and the core files.
`ifndef DECIM_DEFINES_SVH
`define DECIM_DEFINES_SVH

`define DIV_FAST        6'd4
`define DIV_MID         6'd8
`define DIV_SLOW        6'd40
`define OSR_NORMAL      8'd64
`define OSR_HIGHRES     8'd128
`define SETTLE_NORMAL   7'd76
`define SETTLE_HIGHRES  7'd78
`define CODE_MAX        24'h7fffff
`define CODE_MIN        24'h800000
`define RESULT_WIDTH    24

`endif

// file: shared/decim_pkg.sv
// Types used by the decimator top module; its channel filter uses none of them.
// Assumes the defines header is on the include path.
`include "decim_defines.svh"
`default_nettype none
package decim_pkg;
	typedef enum logic [1:0] {
		MODE_HIGH_SPEED = 2'b00,
		MODE_HIGH_RES   = 2'b01,
		MODE_LOW_POWER  = 2'b10,
		MODE_LOW_SPEED  = 2'b11
	} op_mode_type;

	typedef struct packed {
		logic [5:0] clockDivide;
		logic [7:0] ratio;
		logic [6:0] settleCount;
	} mode_cfg_type;

	typedef enum logic [1:0] {
		ST_SETTLING = 2'b00,
		ST_RUNNING  = 2'b01
	} settle_state_type;
endpackage
`default_nettype wire

// file: core/decim_channel.sv
// One channel of the decimator: a third-order sinc (CIC) filter on the one-bit stream.
// Assumes modTick and outTick come from a shared phase counter so all channels align.
`include "decim_defines.svh"
`default_nettype none
module decim_channel #(
	parameter int ACC_WIDTH = 30
) (
	input  wire logic                      clock,
	input  wire logic                      rst_n,
	input  wire logic                      modTick,
	input  wire logic                      outTick,
	input  wire logic                      restart,
	input  wire logic                      modBit,
	input  wire logic [7:0]                ratio,
	output logic      [`RESULT_WIDTH-1:0]  result
);
	// Integrators and combs are all shift/add: taps are symmetric, so group delay is constant
	logic signed [ACC_WIDTH-1:0] int1_r, int2_r, int3_r, int1_nxt, int2_nxt, int3_nxt;
	logic signed [ACC_WIDTH-1:0] dly1_r, dly2_r, dly3_r, dly1_nxt, dly2_nxt, dly3_nxt;
	logic        [`RESULT_WIDTH-1:0] result_r, result_nxt;
	logic signed [ACC_WIDTH-1:0] c1, c2, c3, scaled;
	logic signed [ACC_WIDTH-1:0] sample;

	function automatic logic [`RESULT_WIDTH-1:0] clip(input logic signed [ACC_WIDTH-1:0] v);
		if (v > $signed({{(ACC_WIDTH-`RESULT_WIDTH){1'b0}}, `CODE_MAX}))
			return `CODE_MAX;
		else if (v < $signed({{(ACC_WIDTH-`RESULT_WIDTH){1'b1}}, `CODE_MIN}))
			return `CODE_MIN;
		else
			return v[`RESULT_WIDTH-1:0];
	endfunction

	always_comb begin
		sample   = modBit ? ACC_WIDTH'(1) : -ACC_WIDTH'(1);
		int1_nxt = int1_r;
		int2_nxt = int2_r;
		int3_nxt = int3_r;
		dly1_nxt = dly1_r;
		dly2_nxt = dly2_r;
		dly3_nxt = dly3_r;
		result_nxt = result_r;
		c1 = int3_r - dly1_r;
		c2 = c1 - dly2_r;
		c3 = c2 - dly3_r;
		// Gain is ratio cubed; scale to 24 bits: 64^3=2^18 -> <<5, 128^3=2^21 -> <<2
		scaled = (ratio == `OSR_HIGHRES) ? (c3 <<< 2) : (c3 <<< 5);
		if (restart) begin
			int1_nxt = '0; int2_nxt = '0; int3_nxt = '0;
			dly1_nxt = '0; dly2_nxt = '0; dly3_nxt = '0;
		end else if (modTick) begin
			int1_nxt = int1_r + sample;
			int2_nxt = int2_r + int1_r;
			int3_nxt = int3_r + int2_r;
			if (outTick) begin
				dly1_nxt   = int3_r;
				dly2_nxt   = c1;
				dly3_nxt   = c2;
				result_nxt = clip(scaled);
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			int1_r <= '0; int2_r <= '0; int3_r <= '0;
			dly1_r <= '0; dly2_r <= '0; dly3_r <= '0;
			result_r <= '0;
		end else begin
			int1_r <= int1_nxt; int2_r <= int2_nxt; int3_r <= int3_nxt;
			dly1_r <= dly1_nxt; dly2_r <= dly2_nxt; dly3_r <= dly3_nxt;
			result_r <= result_nxt;
		end
	end

	assign result = result_r;

	a_clip_range: assert property (@(posedge clock) disable iff (!rst_n)
		$signed(result) <= $signed(`CODE_MAX) && $signed(result) >= $signed(`CODE_MIN))
		else $error("result outside clip range");
	a_result_hold: assert property (@(posedge clock) disable iff (!rst_n)
		!(modTick && outTick) |=> $stable(result))
		else $error("result changed without output tick");
endmodule
`default_nettype wire

// file: sim/result_reader.sv
// Host-side reader: latches every channel's word at each strobe and measures the tick spacing.
// Assumes strobe, tick and results share the master clock of the core.
`include "decim_defines.svh"
`default_nettype none
module result_reader #(
	parameter int CHANNELS = 8
) (
	input  wire logic                              clock,
	input  wire logic                              modTick,
	input  wire logic                              dataStrobe,
	input  wire logic [CHANNELS*`RESULT_WIDTH-1:0] results,
	output var  logic [CHANNELS*`RESULT_WIDTH-1:0] words,
	output var  int                                tickGap,
	output var  int                                ticksPerWord
);
	timeunit 1ns;
	timeprecision 1ns;
	int gap = 0;
	int ticks = 0;
	initial tickGap = 0;
	initial ticksPerWord = 0;
	// Blocking counts so the latched figure includes the current edge
	always @(posedge clock) begin
		gap++;
		if (modTick === 1'b1) begin
			tickGap <= gap;
			gap = 0;
			ticks++;
		end
		if (dataStrobe === 1'b1) begin
			words <= results;
			ticksPerWord <= ticks;
			ticks = 0;
		end
	end
endmodule
`default_nettype wire

// file: sim/multichannel_decimator_bench.sv
// Self-checking bench for the decimator: tick rates, ratios, settling, clipping, zero code.
// Assumes one 50 MHz clock; the bench plays the modulators and the reader plays the host.
`include "decim_defines.svh"
`default_nettype none
module multichannel_decimator_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int CH = 8;
	localparam int W = `RESULT_WIDTH;
	logic              clock = 1'b0;
	logic              rst_n = 1'b0;
	logic [1:0]        modePins = 2'b00;
	logic              clock_divide_select = 1'b1;
	logic [CH-1:0]     modBits;
	logic              alt = 1'b0;
	logic              modTick;
	logic              dataStrobe;
	logic              settled;
	logic [CH*W-1:0]   results;
	logic [CH*W-1:0]   words;
	int                tickGap;
	int                ticksPerWord;
	int                fail_count = 0;
	int                compares = 0;
	int                seed = 11578;
	int                n;
	logic [W-1:0]      expQ[$];
	// Expected divider indexed by {mode, divide select}
	int                divTable[8] = '{4, 4, 4, 4, 4, 8, 8, 40};

	multichannel_decimator #(.CHANNELS(CH)) uut (.clock(clock), .rst_n(rst_n), .modePins(modePins),
		.clock_divide_select(clock_divide_select), .modBits(modBits), .modTick(modTick),
		.dataStrobe(dataStrobe), .settled(settled), .results(results));
	result_reader #(.CHANNELS(CH)) host (.clock(clock), .modTick(modTick), .dataStrobe(dataStrobe),
		.results(results), .words(words), .tickGap(tickGap), .ticksPerWord(ticksPerWord));

	initial forever #10 clock = ~clock;

	// Half-density stream: every channel flips on each modulator tick
	always @(posedge clock) if (alt && modTick === 1'b1) modBits <= ~modBits;

	task automatic check(string what, logic [W-1:0] exp, logic [W-1:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic strobes(int k);
		repeat (k) begin
			do begin
				@(posedge clock);
				#1;
			end while (dataStrobe !== 1'b1);
		end
	endtask

	// Counts strobes from the restart up to and including the one that raises settled
	task automatic settleCount(int exp);
		n = 0;
		do begin
			@(posedge clock);
			#1;
			if (dataStrobe === 1'b1)
				n++;
		end while (settled !== 1'b1);
		check("settle conversions", exp, n);
	endtask

	task automatic clipCheck(logic [CH-1:0] bits);
		@(posedge clock) modBits <= bits;
		strobes(5);
		for (int c = 0; c < CH; c++) begin
			expQ.push_back(bits[c] ? `CODE_MAX : `CODE_MIN);
			check("channel word", expQ.pop_front(), words[c*W +: W]);
		end
	endtask

	initial begin
		logic [CH-1:0] bits;
		bits = $random(seed);
		modBits = bits;
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		settleCount(76);
		clipCheck(bits);
		clipCheck(~bits);
		@(posedge clock) alt <= 1'b1;
		strobes(5);
		for (int c = 0; c < CH; c++) begin
			n = $signed(words[c*W +: W]);
			// One code of slack covers where the filter's scaling rounds its midpoint
			check("zero word", 24'h000000, (n >= -1 && n <= 1) ? 24'h000000 : n[W-1:0]);
		end
		@(posedge clock) alt <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			@(posedge clock) begin
				modePins <= i[2:1];
				clock_divide_select <= i[0];
			end
			// Three strobes: one may be left from the old mode and the next may straddle the restart
			strobes(3);
			check("tick gap", divTable[i], tickGap);
			check("ticks per word", (i[2:1] == 2'b01) ? 128 : 64, ticksPerWord);
		end
		@(posedge clock) modePins <= 2'b01;
		repeat (8) @(posedge clock);
		#1;
		check("settled cleared", 24'h000000, {23'h000000, settled});
		settleCount(78);
		wrap_up();
	end

	// Longest path is about 79k cycles of settling, clipping and mode sweeps
	initial begin
		repeat (100000) @(posedge clock);
		fail_count++;
		wrap_up();
	end
endmodule
`default_nettype wire
